/* rtl/asr_pkg.sv */
// Package with register map, field positions, reset values and timing counts for the serial receiver.
package asr_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL1  = 4'h0;
   localparam logic [3:0] ADDR_CTRL2  = 4'h1;
   localparam logic [3:0] ADDR_CTRL3  = 4'h2;
   localparam logic [3:0] ADDR_STAT1  = 4'h3;
   localparam logic [3:0] ADDR_DATA   = 4'h4;
   localparam logic [3:0] ADDR_SYS    = 4'h5;
   localparam logic [3:0] ADDR_BAUD   = 4'h6;

   // Control one fields.
   localparam int C1_LOOP  = 7;
   localparam int C1_ENA   = 6;
   localparam int C1_TX_POLARITY_INVERT = 5;
   localparam int C1_MODE9 = 4;
   localparam int C1_WAKE  = 3;
   localparam int C1_IDLE_COUNT_ORIGIN  = 2;
   localparam int C1_PEN   = 1;
   localparam int C1_PODD  = 0;
   // Control two fields.
   localparam int C2_TXIE  = 7;
   localparam int C2_TCIE  = 6;
   localparam int C2_RXIE  = 5;
   localparam int C2_LINE_QUIET_IRQ_EN  = 4;
   localparam int C2_TE    = 3;
   localparam int C2_RE    = 2;
   localparam int C2_STBY  = 1;
   // Control three fields.
   localparam int C3_R8    = 7;
   localparam int C3_OVERRUN_IRQ_EN  = 3;
   localparam int C3_NOISE_IRQ_EN  = 2;
   localparam int C3_FRAMING_IRQ_EN  = 1;
   localparam int C3_PARITY_IRQ_EN  = 0;
   // Status one fields.
   localparam int S1_TXE   = 7;
   localparam int S1_TC    = 6;
   localparam int S1_FULL  = 5;
   localparam int S1_IDLE  = 4;
   localparam int S1_OR    = 3;
   localparam int S1_NF    = 2;
   localparam int S1_FE    = 1;
   localparam int S1_PE    = 0;
   // System register fields.
   localparam int SY_BREAK_FLAG_CLEAR_EN  = 2;
   localparam int SY_BRK   = 1;
   localparam int SY_STOP  = 0;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'hC0;
   localparam logic [7:0] BAUD_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ       = 20_000_000;
   localparam int TICKS_PER_BIT = 16;
   localparam logic [3:0] T_START3 = 4'h3;
   localparam logic [3:0] T_START5 = 4'h5;
   localparam logic [3:0] T_START7 = 4'h7;
   localparam logic [3:0] T_S8     = 4'h8;
   localparam logic [3:0] T_S9     = 4'h9;
   localparam logic [3:0] T_S10    = 4'hA;
   localparam logic [3:0] T_LAST   = 4'hF;
   localparam logic [3:0] IDLE_8BIT = 4'hA;
   localparam logic [3:0] IDLE_9BIT = 4'hB;

   // Receiver frame states.
   typedef enum logic [1:0] {ASR_HUNT, ASR_START, ASR_DATA, ASR_STOP} asr_state_e;

   // Bus request bundle.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } asr_bus_s;

   // Serial pins as seen by the block.
   typedef struct packed {
      logic tx_out;
      logic tx_oe;
      logic rx_oe;
   } asr_pins_s;

endpackage

/* rtl/asr_rx.sv */
// Serial receiver with standby wakeup, status flags, interrupt requests and pin takeover.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
module asr_rx
   import asr_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Register port.
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output      logic [7:0]  rdata,
   // Processor states.
   input  wire logic        cpu_stop,
   input  wire logic        dbg_break,
   // Serial pins and transmitter data.
   input  wire logic        rx_pin,
   input  wire logic        tx_data,
   output      logic        tx_pin,
   output      logic        tx_pin_oe,
   input  wire logic        port_tx_dir,
   input  wire logic        port_rx_dir,
   output      logic        rx_pin_oe,
   // Interrupt requests.
   output      logic        rx_irq,
   output      logic        err_irq,
   output      logic        tx_irq
);

   // ------------------------------------------------------------------
   // Reset and input synchronisation
   // ------------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   logic [1:0] rx_sync_reg;
   logic [1:0] stop_sync_reg;
   logic [1:0] brk_sync_reg;

   // Reset release goes through two flops.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Pin and state inputs pass two flops each.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync_reg   <= 2'b11;
         stop_sync_reg <= 2'b00;
         brk_sync_reg  <= 2'b00;
      end else begin
         rx_sync_reg   <= {rx_sync_reg[0], rx_pin};
         stop_sync_reg <= {stop_sync_reg[0], cpu_stop};
         brk_sync_reg  <= {brk_sync_reg[0], dbg_break};
      end
   end

   // ------------------------------------------------------------------
   // Registers and derived controls
   // ------------------------------------------------------------------
   logic [7:0] ctrl1_reg, ctrl2_reg, ctrl3_reg, stat_reg, data_reg, baud_reg;
   logic       break_flag_clear_en_reg, r8_reg, err_rd_reg;
   logic       enable, loop_mode, halted, in_break, may_clear, rx_on;
   logic       rx_line, frame_done, char_ok, wake_mark, idle_seen;

   assign halted    = stop_sync_reg[1];
   assign in_break  = brk_sync_reg[1];
   assign may_clear = !in_break || break_flag_clear_en_reg;
   assign enable    = ctrl1_reg[C1_ENA];
   assign loop_mode = ctrl1_reg[C1_LOOP];
   assign rx_on     = enable && ctrl2_reg[C2_RE] && !halted;
   // Loopback takes the transmitter output in place of the pin.
   assign rx_line   = loop_mode ? tx_data : rx_sync_reg[1];

   // ------------------------------------------------------------------
   // Sample tick divider
   // ------------------------------------------------------------------
   logic [7:0] div_reg;
   logic       tick;

   // Tick period is baud register plus one clocks, sixteen ticks a bit.
   assign tick = rx_on && (div_reg == baud_reg);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 8'h00;
      end else if (!rx_on || tick) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Frame receiver
   // ------------------------------------------------------------------
   asr_state_e  st_reg;
   logic [3:0]  rt_reg, bit_reg, ones_reg;
   logic [8:0]  shf_reg;
   logic [2:0]  smp_reg;
   logic        nz_reg, idle_arm_reg, start3_reg;
   logic [3:0]  nbits, idle_len;
   logic        maj, smp_noise, parity_bad, msb;

   // Majority vote and disagreement over three samples.
   function automatic logic vote(input logic [2:0] s);
      vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   assign nbits      = ctrl1_reg[C1_MODE9] ? 4'h9 : 4'h8;
   assign idle_len   = ctrl1_reg[C1_MODE9] ? IDLE_9BIT : IDLE_8BIT;
   assign maj        = vote({smp_reg[1:0], rx_line});
   assign smp_noise  = ({smp_reg[1:0], rx_line} != 3'b000) && ({smp_reg[1:0], rx_line} != 3'b111);
   // Parity bit sits in the most significant received position.
   assign parity_bad = ctrl1_reg[C1_PEN] &&
                       ((ctrl1_reg[C1_MODE9] ? ^shf_reg : ^shf_reg[8:1]) != ctrl1_reg[C1_PODD]);
   assign msb        = ctrl1_reg[C1_MODE9] ? shf_reg[8] : shf_reg[8];
   assign frame_done = tick && st_reg == ASR_STOP && rt_reg == T_S10;
   assign wake_mark  = ctrl1_reg[C1_WAKE] && msb;
   assign char_ok    = frame_done && (!ctrl2_reg[C2_STBY] || wake_mark);
   assign idle_seen  = tick && rt_reg == T_LAST && ones_reg == idle_len - 4'h1 && rx_line && idle_arm_reg;

   // Bit timing and shifting, run on the sixteen-times tick.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg  <= ASR_HUNT;
         rt_reg  <= 4'h0;
         bit_reg <= 4'h0;
         shf_reg <= 9'h000;
         smp_reg <= 3'b000;
         nz_reg  <= 1'b0;
         start3_reg <= 1'b0;
      end else if (!rx_on) begin
         st_reg  <= ASR_HUNT;
         rt_reg  <= 4'h0;
      end else if (tick) begin
         rt_reg  <= rt_reg + 4'h1;
         smp_reg <= {smp_reg[1:0], rx_line};
         case (st_reg)
            ASR_HUNT: begin
               // Tick count runs free here so idle bit times stay timed.
               if (!rx_line && smp_reg == 3'b111) begin
                  st_reg <= ASR_START;
                  rt_reg <= 4'h2;
                  nz_reg <= 1'b0;
               end
            end
            ASR_START: begin
               // The third sample is kept, as the sample history is only three deep.
               if (rt_reg == T_START3) begin
                  start3_reg <= rx_line;
               end
               if (rt_reg == T_START7) begin
                  // Samples at three, five and seven verify the start.
                  if (vote({start3_reg, smp_reg[1], rx_line})) begin
                     st_reg <= ASR_HUNT;
                  end else if ({start3_reg, smp_reg[1], rx_line} != 3'b000) begin
                     nz_reg <= 1'b1;
                  end
               end
               if (rt_reg == T_LAST) begin
                  st_reg  <= ASR_DATA;
                  bit_reg <= 4'h0;
               end
            end
            ASR_DATA: begin
               if (rt_reg == T_S10) begin
                  shf_reg <= ctrl1_reg[C1_MODE9] ? {maj, shf_reg[8:1]} : {maj, shf_reg[8:2], 1'b0};
                  if (smp_noise) begin
                     nz_reg <= 1'b1;
                  end
               end
               if (rt_reg == T_LAST) begin
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == nbits - 4'h1) begin
                     st_reg <= ASR_STOP;
                  end
               end
            end
            ASR_STOP: begin
               // Stop bit is decided at tick ten so a fast bit still counts.
               if (rt_reg == T_S10) begin
                  st_reg <= ASR_HUNT;
               end
            end
            default: st_reg <= ASR_HUNT;
         endcase
      end
   end

   // Idle counting of consecutive ones from start or stop origin.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_reg     <= 4'h0;
         idle_arm_reg <= 1'b0;
      end else if (!rx_on) begin
         ones_reg     <= 4'h0;
      end else if (tick && rt_reg == T_LAST) begin
         if (!rx_line || (st_reg != ASR_HUNT && ctrl1_reg[C1_IDLE_COUNT_ORIGIN])) begin
            ones_reg <= 4'h0;
         end else if (ones_reg != idle_len) begin
            ones_reg <= ones_reg + 4'h1;
         end
         if (!rx_line) begin
            idle_arm_reg <= 1'b1;
         end else if (idle_seen) begin
            idle_arm_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Status flags and register writes
   // ------------------------------------------------------------------
   logic set_full, set_idle, set_or, set_nf, set_fe, set_pe, clr_ok, clr_flags, wake_idle;

   assign wake_idle = idle_seen && ctrl2_reg[C2_STBY] && !ctrl1_reg[C1_WAKE];
   assign set_full  = char_ok && !stat_reg[S1_FULL];
   assign set_or    = char_ok && stat_reg[S1_FULL];
   assign set_idle  = idle_seen && !ctrl2_reg[C2_STBY];
   assign set_nf    = set_full && (nz_reg || (smp_noise));
   assign set_fe    = set_full && !maj;
   assign set_pe    = set_full && parity_bad;
   // Two-step clear: status read arms it, data read completes it.
   assign clr_ok    = may_clear && err_rd_reg && rd_en && addr == ADDR_DATA;
   assign clr_flags = clr_ok;

   // Flag updates; hardware set wins over software clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg <= STAT_RESET;
         data_reg <= 8'h00;
         r8_reg   <= 1'b0;
      end else begin
         if (!enable) begin
            stat_reg[S1_TXE] <= 1'b1;
            stat_reg[S1_TC]  <= 1'b1;
         end
         if (clr_flags) begin
            stat_reg[5:0] <= 6'h00;
         end
         if (set_full) begin
            stat_reg[S1_FULL] <= 1'b1;
            data_reg <= ctrl1_reg[C1_MODE9] ? shf_reg[7:0] : shf_reg[8:1];
            r8_reg   <= ctrl1_reg[C1_MODE9] ? shf_reg[8] : shf_reg[8];
         end
         if (set_idle) stat_reg[S1_IDLE] <= 1'b1;
         if (set_or)   stat_reg[S1_OR]   <= 1'b1;
         if (set_nf)   stat_reg[S1_NF]   <= 1'b1;
         if (set_fe)   stat_reg[S1_FE]   <= 1'b1;
         if (set_pe)   stat_reg[S1_PE]   <= 1'b1;
      end
   end

   // Control writes, standby wakeup and the first step of clearing.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1_reg   <= CTRL_RESET;
         ctrl2_reg   <= CTRL_RESET;
         ctrl3_reg   <= CTRL_RESET;
         baud_reg    <= BAUD_RESET;
         break_flag_clear_en_reg    <= 1'b0;
         err_rd_reg  <= 1'b0;
      end else begin
         if (wr_en && addr == ADDR_CTRL1) ctrl1_reg <= wdata;
         if (wr_en && addr == ADDR_CTRL2) begin
            // Transmit and receive enables only change while enabled.
            ctrl2_reg <= enable ? wdata : {wdata[7:4], ctrl2_reg[3:2], wdata[1:0]};
         end
         if (wr_en && addr == ADDR_CTRL3) ctrl3_reg <= wdata;
         if (wr_en && addr == ADDR_BAUD)  baud_reg  <= wdata;
         if (wr_en && addr == ADDR_SYS)   break_flag_clear_en_reg  <= wdata[SY_BREAK_FLAG_CLEAR_EN];
         if ((char_ok && wake_mark) || wake_idle) begin
            ctrl2_reg[C2_STBY] <= 1'b0;
         end
         // Arming only happens when clearing is allowed; it holds across a break.
         if (rd_en && addr == ADDR_STAT1 && may_clear) begin
            err_rd_reg <= 1'b1;
         end else if (clr_ok) begin
            err_rd_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Read data, pins and interrupt requests
   // ------------------------------------------------------------------
   logic [7:0] rd_mux;
   logic       rx_req, err_req, tx_req;

   assign rd_mux = (addr == ADDR_CTRL1) ? ctrl1_reg :
                   (addr == ADDR_CTRL2) ? ctrl2_reg :
                   (addr == ADDR_CTRL3) ? {r8_reg, ctrl3_reg[6:0]} :
                   (addr == ADDR_STAT1) ? stat_reg :
                   (addr == ADDR_DATA)  ? data_reg :
                   (addr == ADDR_SYS)   ? {5'h00, break_flag_clear_en_reg, in_break, halted} :
                   (addr == ADDR_BAUD)  ? baud_reg : 8'h00;
   // Standby and stop both mute the receiver requests.
   assign rx_req  = !halted && !ctrl2_reg[C2_STBY] &&
                    ((stat_reg[S1_FULL] && ctrl2_reg[C2_RXIE]) || (stat_reg[S1_IDLE] && ctrl2_reg[C2_LINE_QUIET_IRQ_EN]));
   assign err_req = !halted && !ctrl2_reg[C2_STBY] &&
                    ((stat_reg[S1_OR] && ctrl3_reg[C3_OVERRUN_IRQ_EN]) || (stat_reg[S1_NF] && ctrl3_reg[C3_NOISE_IRQ_EN]) ||
                     (stat_reg[S1_FE] && ctrl3_reg[C3_FRAMING_IRQ_EN]) || (stat_reg[S1_PE] && ctrl3_reg[C3_PARITY_IRQ_EN]));
   assign tx_req  = !halted && enable &&
                    ((stat_reg[S1_TXE] && ctrl2_reg[C2_TXIE]) || (stat_reg[S1_TC] && ctrl2_reg[C2_TCIE]));

   // Outputs are registered.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata     <= 8'h00;
         tx_pin    <= 1'b1;
         tx_pin_oe <= 1'b0;
         rx_pin_oe <= 1'b0;
         rx_irq    <= 1'b0;
         err_irq   <= 1'b0;
         tx_irq    <= 1'b0;
      end else begin
         rdata     <= rd_en ? rd_mux : 8'h00;
         tx_pin    <= tx_data ^ ctrl1_reg[C1_TX_POLARITY_INVERT];
         tx_pin_oe <= enable ? 1'b1 : port_tx_dir;
         rx_pin_oe <= enable ? 1'b0 : port_rx_dir;
         rx_irq    <= rx_req;
         err_irq   <= err_req;
         tx_irq    <= tx_req;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   standby_mute_a: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl2_reg[C2_STBY] |=> !rx_irq) else $error("receiver request during standby");
   stop_mute_a: assert property (@(posedge clk) disable iff (!rst_n)
      halted |=> !rx_irq && !err_irq) else $error("request during stop state");
   full_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      set_full |=> stat_reg[S1_FULL]) else $error("full flag not set");
   overrun_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      set_or |=> stat_reg[S1_OR] && $stable(data_reg)) else $error("overrun lost old data");
   fe_with_full_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(stat_reg[S1_FE]) |-> $rose(stat_reg[S1_FULL])) else $error("framing not with full");
   mark_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
      char_ok && wake_mark |=> !ctrl2_reg[C2_STBY]) else $error("mark did not wake");
   idle_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
      wake_idle |=> !ctrl2_reg[C2_STBY] && !$rose(stat_reg[S1_IDLE])) else $error("idle wake wrong");
   pin_take_a: assert property (@(posedge clk) disable iff (!rst_n)
      enable |=> tx_pin_oe && !rx_pin_oe) else $error("pins not taken over");
   break_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      in_break && !break_flag_clear_en_reg && !set_nf |=> stat_reg[S1_NF] >= $past(stat_reg[S1_NF])) else $error("flag cleared in break");
   disable_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
      !enable |=> stat_reg[S1_TXE] && stat_reg[S1_TC]) else $error("tx flags not set on disable");

endmodule

/* tb/asr_remote.sv */
// Remote transmitter model that frames characters onto the receive line.
`timescale 1ns/10ps
module asr_remote
(
   // Clock.
   input  wire logic clk,
   // Serial line toward the block.
   output      logic line
);
   // Line rests at the stop level between frames.
   initial line = 1'b1;
   // Sends start, eight data bits least first, then the stop level given.
   task automatic send(input logic [7:0] data, input logic stop_lvl);
      logic [9:0] frame;
      frame = {stop_lvl, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         repeat (16) @(posedge clk);
         line <= frame[i];
      end
      repeat (16) @(posedge clk);
      line <= 1'b1;
   endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the serial receiver.
`timescale 1ns/10ps
module testbench;
   import asr_pkg::*;
   logic       clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, tx_data = 1'b1;
   logic       port_tx_dir = 1'b0, port_rx_dir = 1'b1, cpu_stop = 1'b0, dbg_break = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, s;
   logic       rx_line, tx_pin, tx_pin_oe, rx_pin_oe, rx_irq, err_irq, tx_irq;
   int         fail_count = 0, tests_run = 0, cycles = 0;
   // Clock at 20 MHz.
   always #25 clk = ~clk;
   asr_remote rem (.clk(clk), .line(rx_line));
   asr_rx dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .cpu_stop(cpu_stop), .dbg_break(dbg_break), .rx_pin(rx_line), .tx_data(tx_data),
      .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .port_tx_dir(port_tx_dir), .port_rx_dir(port_rx_dir),
      .rx_pin_oe(rx_pin_oe), .rx_irq(rx_irq), .err_irq(err_irq), .tx_irq(tx_irq));
   // Register write of one cycle.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   // Register read; data stand in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask
   // Compares one byte and counts the result.
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Sends one character and lets the receiver settle.
   task automatic frame(input logic [7:0] d, input logic stop_lvl);
      rem.send(d, stop_lvl);
      repeat (8) @(posedge clk);
   endtask
   // Reset values and pin defaults.
   task automatic t_reset();
      rd(ADDR_CTRL1, s);
      check(s, CTRL_RESET);
      rd(ADDR_STAT1, s);
      check(s, STAT_RESET);
      check({7'h00, tx_pin}, 8'h01);
      check({6'h00, tx_pin_oe, rx_pin_oe}, 8'h01);
      rd(4'hF, s);
      check(s, 8'h00);
   endtask
   // Enabling takes over both pins against the port direction bits.
   task automatic t_enable();
      wr(ADDR_CTRL1, 8'h40);
      wr(ADDR_CTRL2, 8'h24);
      wr(ADDR_CTRL3, 8'h0A);
      repeat (2) @(posedge clk);
      check({6'h00, tx_pin_oe, rx_pin_oe}, 8'h02);
      rd(ADDR_CTRL2, s);
      check(s, 8'h24);
   endtask
   // A good character sets full, requests, and reads back.
   task automatic t_rx();
      frame(8'h5A, 1'b1);
      check({7'h00, rx_irq}, 8'h01);
      rd(ADDR_STAT1, s);
      check(s & 8'h2B, 8'h20);
      rd(ADDR_DATA, s);
      check(s, 8'h5A);
   endtask
   // Two unread characters overrun; the first is kept.
   task automatic t_overrun();
      frame(8'h11, 1'b1);
      frame(8'h22, 1'b1);
      check({7'h00, err_irq}, 8'h01);
      rd(ADDR_STAT1, s);
      check(s & 8'h28, 8'h28);
      rd(ADDR_DATA, s);
      check(s, 8'h11);
   endtask
   // A zero stop level gives a framing error beside full.
   task automatic t_framing();
      frame(8'h33, 1'b0);
      check({7'h00, err_irq}, 8'h01);
      rd(ADDR_STAT1, s);
      check(s & 8'h22, 8'h22);
      rd(ADDR_DATA, s);
      check(s, 8'h33);
   endtask
   // Address mark standby ignores plain characters and wakes on a mark.
   task automatic t_standby();
      wr(ADDR_CTRL1, 8'h48);
      wr(ADDR_CTRL2, 8'h26);
      frame(8'h12, 1'b1);
      check({7'h00, rx_irq}, 8'h00);
      rd(ADDR_STAT1, s);
      check(s & 8'h20, 8'h00);
      frame(8'h92, 1'b1);
      rd(ADDR_CTRL2, s);
      check(s, 8'h24);
      rd(ADDR_STAT1, s);
      check(s & 8'h20, 8'h20);
      rd(ADDR_DATA, s);
      check(s, 8'h92);
   endtask
   // Parity: a good even character passes, a bad one flags and requests.
   task automatic t_parity();
      wr(ADDR_CTRL1, 8'h42);
      wr(ADDR_CTRL3, 8'h0B);
      frame(8'h81, 1'b1);
      rd(ADDR_STAT1, s);
      check(s & 8'h21, 8'h20);
      rd(ADDR_DATA, s);
      check(s, 8'h81);
      frame(8'h01, 1'b1);
      check({7'h00, err_irq}, 8'h01);
      rd(ADDR_STAT1, s);
      check(s & 8'h21, 8'h21);
      rd(ADDR_DATA, s);
      check(s, 8'h01);
   endtask
   // Idle line wakes standby silently; a later idle sets the flag and requests.
   task automatic t_idle();
      wr(ADDR_CTRL1, 8'h40);
      wr(ADDR_CTRL2, 8'h36);
      frame(8'h00, 1'b1);
      repeat (200) @(posedge clk);
      rd(ADDR_CTRL2, s);
      check(s, 8'h34);
      rd(ADDR_STAT1, s);
      check(s & 8'h30, 8'h00);
      frame(8'h00, 1'b1);
      repeat (200) @(posedge clk);
      check({7'h00, rx_irq}, 8'h01);
      rd(ADDR_STAT1, s);
      check(s & 8'h30, 8'h30);
      rd(ADDR_DATA, s);
      check(s, 8'h00);
      wr(ADDR_CTRL2, 8'h24);
   endtask
   // Stop halts the block and mutes requests; state survives and resumes.
   task automatic t_stop();
      frame(8'h44, 1'b1);
      cpu_stop <= 1'b1;
      repeat (4) @(posedge clk);
      check({7'h00, rx_irq}, 8'h00);
      rd(ADDR_CTRL2, s);
      check(s, 8'h24);
      cpu_stop <= 1'b0;
      repeat (4) @(posedge clk);
      check({7'h00, rx_irq}, 8'h01);
      rd(ADDR_STAT1, s);
      rd(ADDR_DATA, s);
      check(s, 8'h44);
   endtask
   // Break protects flags unless clearing is enabled; an armed clear finishes later.
   task automatic t_break();
      frame(8'h55, 1'b1);
      rd(ADDR_STAT1, s);
      dbg_break <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_DATA, s);
      rd(ADDR_STAT1, s);
      check(s & 8'h20, 8'h20);
      dbg_break <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_DATA, s);
      check(s, 8'h55);
      rd(ADDR_STAT1, s);
      check(s & 8'h20, 8'h00);
      wr(ADDR_SYS, 8'h04);
      frame(8'h66, 1'b1);
      dbg_break <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_STAT1, s);
      rd(ADDR_DATA, s);
      dbg_break <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_STAT1, s);
      check(s & 8'h20, 8'h00);
      wr(ADDR_SYS, 8'h00);
   endtask
   // Loopback takes the transmitter stream while the pin carries a break.
   task automatic t_loop();
      logic [9:0] f;
      f = {1'b1, 8'hC3, 1'b0};
      wr(ADDR_CTRL1, 8'hC0);
      wr(ADDR_CTRL2, 8'h2C);
      fork
         rem.send(8'h00, 1'b0);
         for (int i = 0; i < 10; i++) begin
            tx_data <= f[i];
            repeat (16) @(posedge clk);
         end
      join
      rd(ADDR_STAT1, s);
      check(s & 8'h22, 8'h20);
      rd(ADDR_DATA, s);
      check(s, 8'hC3);
   endtask
   // Inversion flips the transmitted level.
   task automatic t_tx_polarity_invert();
      wr(ADDR_CTRL1, 8'h60);
      tx_data <= 1'b0;
      repeat (3) @(posedge clk);
      check({7'h00, tx_pin}, 8'h01);
      tx_data <= 1'b1;
      repeat (3) @(posedge clk);
      check({7'h00, tx_pin}, 8'h00);
   endtask
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   // Main sequence.
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_enable();
      t_rx();
      t_overrun();
      t_framing();
      t_parity();
      t_standby();
      t_idle();
      t_stop();
      t_break();
      t_loop();
      t_tx_polarity_invert();
      conclude();
   end
endmodule
